// ==== core/tdm_flex_map.v ====
// tdm port to frame buffer channel mapping with apb registers
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`include "tdm_flex_map_consts.vh"

module tdm_flex_map (
   // clock, reset, enable
   input wire pclk,
   input wire presetn,
   input wire ce,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   // tdm pins
   input wire tdm_bit_clock,
   input wire tdm_frame_sync,
   input wire [3:0] tdm_receive_pin,
   output reg [3:0] tdm_transmit_pin,
   // bus slot side
   input wire superframe_start,
   input wire tx_fill_valid,
   input wire [4:0] tx_fill_index,
   input wire [31:0] tx_fill_data,
   input wire dn_rd_en,
   input wire [4:0] dn_rd_slot,
   output reg [31:0] dn_rd_data,
   input wire up_rd_en,
   input wire [4:0] up_rd_slot,
   output reg [31:0] up_rd_data,
   output wire [5:0] active_slot_count
);

   ////////////////////////////////////////////////////////////////////////
   // registers
   reg [10:0] config_ff;
   reg [5:0] slot_count_staged_ff;
   reg [5:0] slot_count_ff;
   reg [5:0] main_tx_channel_skip_ff;
   reg [4:0] downstream_buffer_skip_ff;
   reg [4:0] upstream_buffer_skip_ff;
   reg [63:0] rx_channel_accept_mask_ff;
   reg [4:0] tx_channel_source_select_ff [0:31];
   reg bank_ff;
   reg in_frame_ff;
   reg [7:0] frame_count_ff;
   reg [31:0] tx_buf [0:63];
   reg [31:0] rx_buf [0:63];

   wire wr_en = ce && psel && penable && pwrite;
   wire setup = ce && psel && !penable;
   wire main_node = config_ff[`CFG_MAIN_NODE];
   wire [1:0] tx_pins_m1 = config_ff[`CFG_TX_PINS_HI:`CFG_TX_PINS_LO];
   wire [1:0] rx_pins_m1 = config_ff[`CFG_RX_PINS_HI:`CFG_RX_PINS_LO];
   wire [2:0] tdm_mode = config_ff[`CFG_TDM_MODE_HI:`CFG_TDM_MODE_LO];
   wire tx_ilv = config_ff[`CFG_TX_INTERLEAVE] && (tx_pins_m1 == 2'd1);
   wire rx_ilv = config_ff[`CFG_RX_INTERLEAVE] && (rx_pins_m1 == 2'd1);
   // channels per pin is 2 << mode, mode 4 caps at 32
   wire [2:0] mode_c = (tdm_mode > 3'd4) ? 3'd4 : tdm_mode;
   wire [5:0] chans_per_pin = 6'd2 << mode_c;
   wire [7:0] xbar_idx = (paddr - `OFS_TX_XBAR_BASE) >> 2;
   wire [7:0] mask_idx = (paddr - `OFS_RX_MASK_BASE) >> 2;
   wire xbar_hit = (paddr >= `OFS_TX_XBAR_BASE) && (paddr <= `OFS_TX_XBAR_LAST);
   wire mask_hit = (paddr >= `OFS_RX_MASK_BASE) && (paddr <= `OFS_RX_MASK_LAST);
   wire aligned = (paddr[1:0] == 2'b00);
   integer i;

   assign pready = 1'b1;
   assign active_slot_count = slot_count_ff;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_ff <= `CFG_RESET;
         slot_count_staged_ff <= `SLOT_COUNT_RESET;
         slot_count_ff <= `SLOT_COUNT_RESET;
         main_tx_channel_skip_ff <= `SKIP_RESET;
         downstream_buffer_skip_ff <= 5'h00;
         upstream_buffer_skip_ff <= 5'h00;
         rx_channel_accept_mask_ff <= {8{`RX_MASK_RESET}};
         for (i = 0; i < 32; i = i + 1) begin
            tx_channel_source_select_ff[i] <= i[4:0];
         end
      end else if (wr_en && aligned) begin
         case (paddr)
            `OFS_MAP_CONFIG: config_ff <= pwdata[10:0];
            `OFS_BUS_CONTROL: begin
               if (pwdata[`CTL_STRUCTURE_UPDATE]) begin
                  slot_count_ff <= slot_count_staged_ff;
               end
            end
            `OFS_SLOT_COUNT: slot_count_staged_ff <= (pwdata[5:0] > 6'd32) ? 6'd32 :
               pwdata[5:0];
            `OFS_MAIN_TX_SKIP: main_tx_channel_skip_ff <= pwdata[5:0];
            `OFS_DN_SKIP: downstream_buffer_skip_ff <= pwdata[4:0];
            `OFS_UP_SKIP: upstream_buffer_skip_ff <= pwdata[4:0];
            default: begin
               if (xbar_hit) begin
                  tx_channel_source_select_ff[xbar_idx[4:0]] <= pwdata[4:0];
               end
               if (mask_hit) begin
                  rx_channel_accept_mask_ff[mask_idx[2:0]*8 +: 8] <= pwdata[7:0];
               end
            end
         endcase
      end
   end

   // read data captured in setup phase, valid through access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (!aligned) begin
            pslverr <= 1'b1;
         end else if (xbar_hit) begin
            prdata <= {27'h000_0000, tx_channel_source_select_ff[xbar_idx[4:0]]};
         end else if (mask_hit) begin
            prdata <= {24'h00_0000, rx_channel_accept_mask_ff[mask_idx[2:0]*8 +: 8]};
         end else begin
            case (paddr)
               `OFS_MAP_CONFIG: prdata <= {21'h00_0000, config_ff};
               `OFS_BUS_CONTROL: prdata <= 32'h0000_0000;
               `OFS_SLOT_COUNT: prdata <= {26'h000_0000, slot_count_staged_ff};
               `OFS_MAIN_TX_SKIP: prdata <= {26'h000_0000, main_tx_channel_skip_ff};
               `OFS_DN_SKIP: prdata <= {27'h000_0000, downstream_buffer_skip_ff};
               `OFS_UP_SKIP: prdata <= {27'h000_0000, upstream_buffer_skip_ff};
               `OFS_STATUS: prdata <= {10'h000, slot_count_ff, frame_count_ff, 6'h00,
                  in_frame_ff, bank_ff};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers, three stages, change once stages 2 and 3 agree
   reg [5:0] pin_s1_ff;
   reg [5:0] pin_s2_ff;
   reg [5:0] pin_s3_ff;
   reg [5:0] pin_flt_ff;
   wire [5:0] nxt_pin_flt;

   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : pin_filter
         assign nxt_pin_flt[g] = (pin_s2_ff[g] == pin_s3_ff[g]) ? pin_s3_ff[g] :
            pin_flt_ff[g];
      end
   endgenerate

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_ff <= 6'h00;
         pin_s2_ff <= 6'h00;
         pin_s3_ff <= 6'h00;
         pin_flt_ff <= 6'h00;
      end else if (ce) begin
         pin_s1_ff <= {tdm_frame_sync, tdm_bit_clock, tdm_receive_pin};
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
         pin_flt_ff <= nxt_pin_flt;
      end
   end

   wire bclk_rise = nxt_pin_flt[4] && !pin_flt_ff[4];
   wire bclk_fall = !nxt_pin_flt[4] && pin_flt_ff[4];
   wire sync_now = nxt_pin_flt[5];
   wire [3:0] rx_bit = nxt_pin_flt[3:0];

   ////////////////////////////////////////////////////////////////////////
   // bit and channel position
   reg [4:0] bit_ff;
   reg [4:0] chan_ff;
   wire last_bit = (bit_ff == 5'd31);
   wire last_chan = ({1'b0, chan_ff} == chans_per_pin - 6'd1);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_ff <= 5'd0;
         chan_ff <= 5'd0;
         in_frame_ff <= 1'b0;
         frame_count_ff <= 8'h00;
      end else if (ce && bclk_rise) begin
         // sync seen one bit ahead of channel 0 bit 0
         if (sync_now) begin
            bit_ff <= 5'd0;
            chan_ff <= 5'd0;
            in_frame_ff <= 1'b1;
            frame_count_ff <= frame_count_ff + 8'd1;
         end else if (in_frame_ff) begin
            bit_ff <= bit_ff + 5'd1;
            if (last_bit) begin
               chan_ff <= last_chan ? 5'd0 : chan_ff + 5'd1;
               if (last_chan) begin
                  in_frame_ff <= 1'b0;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // transmit path, one lane per pin
   wire [3:0] tx_bit;
   wire [6:0] tx_skip = main_node ? {1'b0, main_tx_channel_skip_ff} : 7'd0;

   generate
      for (g = 0; g < `NUM_PINS; g = g + 1) begin : tx_lane
         localparam [6:0] PIN = g;
         wire [6:0] seq = tx_ilv ? ({1'b0, chan_ff, 1'b0} + PIN) :
            ((PIN << (mode_c + 3'd1)) + {2'b00, chan_ff});
         wire [6:0] logical = seq - tx_skip;
         // only logical channels 0..31 carry data
         wire live = (PIN <= {5'd0, tx_pins_m1}) && (seq >= tx_skip) &&
            (logical < 7'd32);
         wire [4:0] src = tx_channel_source_select_ff[logical[4:0]];
         wire [31:0] word = live ? tx_buf[{bank_ff, src}] : 32'h0000_0000;
         assign tx_bit[g] = in_frame_ff && word[5'd31 - bit_ff];
      end
   endgenerate

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tdm_transmit_pin <= 4'h0;
      end else if (ce && bclk_fall) begin
         tdm_transmit_pin <= tx_bit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive path, masked packing into fill bank
   function [6:0] count_below;
      input [63:0] m;
      input [5:0] n;
      integer k;
      begin
         count_below = 7'd0;
         for (k = 0; k < 64; k = k + 1) begin
            if ((k < n) && m[k]) begin
               count_below = count_below + 7'd1;
            end
         end
      end
   endfunction

   reg [31:0] rx_shift_ff [0:3];
   wire [5:0] rx_idx [0:3];
   wire [6:0] rx_pos [0:3];
   integer j;

   generate
      for (g = 0; g < `NUM_PINS; g = g + 1) begin : rx_lane
         localparam [5:0] PIN = g;
         // mask index in pin distribution order
         assign rx_idx[g] = rx_ilv ? ({chan_ff, 1'b0} + PIN) :
            ((PIN << (mode_c + 3'd1)) + {1'b0, chan_ff});
         assign rx_pos[g] = count_below(rx_channel_accept_mask_ff, rx_idx[g]);
      end
   endgenerate

   always @(posedge pclk) begin
      if (ce) begin
         // bus side fills the idle tx bank
         if (tx_fill_valid) begin
            tx_buf[{~bank_ff, tx_fill_index}] <= tx_fill_data;
         end
         if (bclk_rise && in_frame_ff && !sync_now) begin
            for (j = 0; j < `NUM_PINS; j = j + 1) begin
               rx_shift_ff[j] <= {rx_shift_ff[j][30:0], rx_bit[j]};
               if (last_bit && (j <= rx_pins_m1) && rx_channel_accept_mask_ff[rx_idx[j]] &&
                  (rx_pos[j] < {1'b0, slot_count_ff}) && (rx_pos[j] < 7'd32)) begin
                  rx_buf[{~bank_ff, rx_pos[j][4:0]}] <= {rx_shift_ff[j][30:0], rx_bit[j]};
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bank swap and bus readout
   wire [5:0] dn_loc = {1'b0, dn_rd_slot} + (main_node ? 6'd0 :
      {1'b0, downstream_buffer_skip_ff});
   wire [5:0] up_loc = {1'b0, up_rd_slot} + (main_node ? 6'd0 :
      {1'b0, upstream_buffer_skip_ff});

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_ff <= 1'b0;
         dn_rd_data <= 32'h0000_0000;
         up_rd_data <= 32'h0000_0000;
      end else if (ce) begin
         // swap fill and drain each superframe
         if (superframe_start) begin
            bank_ff <= ~bank_ff;
         end
         if (dn_rd_en) begin
            dn_rd_data <= dn_loc[5] ? 32'h0000_0000 : rx_buf[{bank_ff, dn_loc[4:0]}];
         end
         if (up_rd_en) begin
            up_rd_data <= up_loc[5] ? 32'h0000_0000 : rx_buf[{bank_ff, up_loc[4:0]}];
         end
      end
   end

endmodule // tdm_flex_map

// ==== core/tdm_flex_map_consts.vh ====
// constants for the tdm flexible channel mapping block
`ifndef TDM_FLEX_MAP_CONSTS_VH
`define TDM_FLEX_MAP_CONSTS_VH

// register byte offsets
`define OFS_MAP_CONFIG      8'h00
`define OFS_BUS_CONTROL     8'h04
`define OFS_SLOT_COUNT      8'h08
`define OFS_MAIN_TX_SKIP    8'h0C
`define OFS_DN_SKIP         8'h10
`define OFS_UP_SKIP         8'h14
`define OFS_STATUS          8'h18
`define OFS_RX_MASK_BASE    8'h20
`define OFS_RX_MASK_LAST    8'h3C
`define OFS_TX_XBAR_BASE    8'h40
`define OFS_TX_XBAR_LAST    8'hBC

// map_config fields
`define CFG_MAIN_NODE       0
`define CFG_TX_INTERLEAVE   1
`define CFG_RX_INTERLEAVE   2
`define CFG_TX_PINS_LO      4
`define CFG_TX_PINS_HI      5
`define CFG_RX_PINS_LO      6
`define CFG_RX_PINS_HI      7
`define CFG_TDM_MODE_LO     8
`define CFG_TDM_MODE_HI     10
`define CFG_RESET           11'h000

// bus_control_reg fields
`define CTL_STRUCTURE_UPDATE 0

// reset values
`define SLOT_COUNT_RESET    6'h20
`define RX_MASK_RESET       8'hFF
`define SKIP_RESET          6'h00

// sizes
`define BUF_DEPTH           32
`define CHAN_BITS           32
`define RX_CHANNELS         64
`define NUM_PINS            4

`endif

// ==== tb/tdm_flex_map_properties.sv ====
// port assertions for the channel mapping block
module tdm_flex_map_properties (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // tdm and slots
   input wire tdm_bit_clock,
   input wire [3:0] tdm_transmit_pin,
   input wire [5:0] active_slot_count
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire bad = (paddr[1:0] != 2'b00) || (paddr > 8'h18 && paddr < 8'h20) || (paddr > 8'hBC);
   sequence s_setup;
      psel && !penable && ce;
   endsequence
   sequence s_read(lo, hi);
      s_setup ##0 (!pwrite && paddr >= lo && paddr <= hi);
   endsequence
   //////////////////////////////
   a_ready_high: assert property (pready)
      else $error("pready low");
   a_err_bad_addr: assert property (s_setup |=> pslverr == $past(bad))
      else $error("pslverr wrong");
   a_ctl_reads_zero: assert property (s_read(8'h04, 8'h04) |=> prdata == 32'h0000_0000)
      else $error("control read not zero");
   a_mask_narrow: assert property (s_read(8'h20, 8'h3C) |=> prdata[31:8] == 24'h00_0000)
      else $error("mask read too wide");
   a_xbar_narrow: assert property (s_read(8'h40, 8'hBC) |=> prdata[31:5] == 27'h000_0000)
      else $error("crossbar read too wide");
   a_tx_quiet: assert property ($stable(tdm_bit_clock)[*8] |=> $stable(tdm_transmit_pin))
      else $error("tx pin moved without clock edge");
   a_slot_hold: assert property ($changed(active_slot_count) |->
      $past(psel && penable && pwrite && ce && paddr == 8'h04)) else $error("slot count moved");
   a_slot_max: assert property (active_slot_count <= 6'h20)
      else $error("slot count above 32");
endmodule // tdm_flex_map_properties

bind tdm_flex_map tdm_flex_map_properties u_props (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .tdm_bit_clock(tdm_bit_clock), .tdm_transmit_pin(tdm_transmit_pin),
   .active_slot_count(active_slot_count));

// ==== tb/tdm_device_model.sv ====
// behavioural tdm audio device on the pin side
module tdm_device_model (
   // tdm pins
   output logic bclk,
   output logic sync,
   output logic [3:0] rx,
   input wire logic [3:0] tx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] rx_word [4][32];
   logic [31:0] tx_word [4][32];
   initial begin
      bclk = 1'b0;
      sync = 1'b0;
      rx = 4'h0;
   end
   // one frame, msb first, clock still outside it
   task automatic run(input int cpp);
      sync = 1'b1;
      #40 bclk = 1'b1;
      #40 bclk = 1'b0;
      sync = 1'b0;
      for (int k = 0; k < 32 * cpp; k++) begin
         for (int p = 0; p < 4; p++) rx[p] = rx_word[p][k / 32][31 - k % 32];
         #40 bclk = 1'b1;
         #39;
         for (int p = 0; p < 4; p++) tx_word[p][k / 32][31 - k % 32] = tx[p];
         #1 bclk = 1'b0;
      end
      // released lines show no stale bit
      rx = ~rx;
   endtask
endmodule // tdm_device_model

// ==== tb/testbench.sv ====
// self-checking bench for the channel mapping block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic sf = 1'b0, fv = 1'b0, dn_en = 1'b0, up_en = 1'b0, pready, pslverr, rerr;
   logic ce = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [4:0] fidx = 5'h00, dn_slot = 5'h00, up_slot = 5'h00;
   logic [31:0] pwdata = 32'h0000_0000, fdat = 32'h0000_0000, prdata, rdat, dn_data, up_data;
   logic [31:0] seed = 32'h0000_0039, txb [32], rxe [32], ws [64];
   logic [3:0] tx_pins, rx_pins;
   logic [5:0] act;
   logic [63:0] mask;
   logic bclk, fsync;
   int err_count = 0, cmp_count = 0, cycles = 0, xb [32], nrx;
   int main_n, pins, ilv, cpp, skip, dskip, uskip;
   tdm_flex_map dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tdm_bit_clock(bclk), .tdm_frame_sync(fsync),
      .tdm_receive_pin(rx_pins), .tdm_transmit_pin(tx_pins), .superframe_start(sf),
      .tx_fill_valid(fv), .tx_fill_index(fidx), .tx_fill_data(fdat), .dn_rd_en(dn_en),
      .dn_rd_slot(dn_slot), .dn_rd_data(dn_data), .up_rd_en(up_en), .up_rd_slot(up_slot),
      .up_rd_data(up_data), .active_slot_count(act));
   tdm_device_model dev (.bclk(bclk), .sync(fsync), .rx(rx_pins), .tx(tx_pins));
   initial begin
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 40000) begin
         err_count++;
         print_verdict();
      end
   end
   //////////////////////////////
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function int seq_of(int p, int c);
      return (ilv && pins == 2) ? 2 * c + p : p * cpp + c;
   endfunction
   function logic [31:0] tx_exp(int s);
      int lg;
      lg = main_n ? s - skip : s;
      return (lg >= 0 && lg < 32) ? txb[xb[lg]] : 32'h0000_0000;
   endfunction
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // ends once pready is high; the global cycle ceiling ends a hung wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdchk(input string n, input int s, input int off, input logic [31:0] g);
      if (main_n) off = 0;
      if (s + off < nrx) chk(n, rxe[s + off], g);
      else if (s + off >= 32) chk(n, 32'h0000_0000, g);
   endtask
   task frame(input int m, input int pn, input int il, input int md, input int sk);
      main_n = m;
      pins = pn;
      ilv = il;
      cpp = 2 << md;
      skip = sk;
      apb(1'b1, 8'h00, 32'(m + il * 6 + (pn - 1) * 80 + md * 256));
      apb(1'b1, 8'h0C, 32'(sk));
      apb(1'b1, 8'h10, 32'(dskip));
      apb(1'b1, 8'h14, 32'(uskip));
      for (int i = 0; i < 8; i++) apb(1'b1, 8'(32 + 4 * i), {24'h00_0000, mask[8 * i +: 8]});
      for (int i = 0; i < 32; i++) begin
         txb[i] = rnd();
         @(posedge pclk);
         fv <= 1'b1;
         fidx <= 5'(i);
         fdat <= txb[i];
      end
      @(posedge pclk);
      fv <= 1'b0;
      sf <= 1'b1;
      @(posedge pclk);
      sf <= 1'b0;
      for (int p = 0; p < 4; p++) for (int c = 0; c < 32; c++) dev.rx_word[p][c] = rnd();
      dev.run(cpp);
      repeat (20) @(posedge pclk);
      sf <= 1'b1;
      @(posedge pclk);
      sf <= 1'b0;
      for (int p = 0; p < pins; p++) for (int c = 0; c < cpp; c++) begin
         chk("tx word", tx_exp(seq_of(p, c)), dev.tx_word[p][c]);
         ws[seq_of(p, c)] = dev.rx_word[p][c];
      end
      for (int p = pins; p < 4; p++) for (int c = 0; c < cpp; c++) begin
         chk("idle tx pin", 32'h0000_0000, dev.tx_word[p][c]);
      end
      nrx = 0;
      for (int s = 0; s < pins * cpp; s++) if (mask[s] && nrx < 32) rxe[nrx++] = ws[s];
      for (int s = 0; s < 32; s++) begin
         @(posedge pclk);
         dn_en <= 1'b1;
         up_en <= 1'b1;
         dn_slot <= 5'(s);
         up_slot <= 5'(s);
         @(posedge pclk);
         dn_en <= 1'b0;
         up_en <= 1'b0;
         @(negedge pclk);
         rdchk("dn slot", s, dskip, dn_data);
         rdchk("up slot", s, uskip, up_data);
      end
      $display("frame test done");
   endtask
   task print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   //////////////////////////////
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 32; i++) begin
         xb[i] = i;
         apb(1'b0, 8'(64 + 4 * i), 32'h0000_0000);
         chk("xbar reset", 32'(i), rdat);
      end
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, 8'(32 + 4 * i), 32'h0000_0000);
         chk("mask reset", 32'h0000_00FF, rdat);
      end
      apb(1'b0, 8'h1C, 32'h0000_0000);
      chk("unmapped err", 32'h0000_0001, {31'h0000_0000, rerr});
      apb(1'b1, 8'h02, 32'h0000_0005);
      chk("unaligned err", 32'h0000_0001, {31'h0000_0000, rerr});
      apb(1'b1, 8'h08, 32'h0000_0014);
      @(negedge pclk);
      chk("slot count", 32'h0000_0020, {26'h000_0000, act});
      apb(1'b1, 8'h04, 32'h0000_0001);
      @(negedge pclk);
      chk("slot count", 32'h0000_0014, {26'h000_0000, act});
      apb(1'b1, 8'h08, 32'h0000_0020);
      apb(1'b1, 8'h04, 32'h0000_0001);
      // clock enable low: write must not land
      @(posedge pclk);
      ce <= 1'b0;
      apb(1'b1, 8'h0C, 32'h0000_0007);
      ce <= 1'b1;
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk("frozen write", 32'h0000_0000, rdat);
      $display("register test done");
      xb[0] = 5;
      xb[1] = int'(rnd() & 32'h0000_001F);
      apb(1'b1, 8'h40, 32'h0000_0005);
      apb(1'b1, 8'h44, 32'(xb[1]));
      dskip = 2;
      uskip = 1;
      mask = {rnd(), rnd()};
      frame(1, 1, 0, 1, 1);
      frame(0, 2, 1, 0, 1);
      mask = 64'hFFFF_FFFF_FFFF_FFFF;
      dskip = 3;
      frame(1, 2, 0, 4, 1);
      // three frames seen, banks back to 0, 32 slots active
      apb(1'b0, 8'h18, 32'h0000_0000);
      chk("status", 32'h0020_0300, rdat);
      $display("status test done");
      print_verdict();
   end
endmodule // testbench
